// *** sscc_synth_ctrl.v ***
// Purpose: synthesizer start-up sequencing, carrier word staging and clock output
// Assumes: AXI4-Lite slave, crystal-stable and PLL-lock come in as inputs
// Notes: registers sit at byte address four times their index
// Functional notes
// - synth step is crystal over 2^19
// - 24-bit carrier word at indices 0x07-0x09
// - upper bytes staged, low byte write commits
// - sequencer starts PLL after coarse cal, on a tx, rx or synth request
// - clock output silent until crystal stable
// - general io five carries reference or divided
// - clock output on after reset, off in sleep
// - coarse calibration at reset, fine per PLL start
// - sequencer starts rx or tx after lock
// - lock indication high within locking range
// - first data clock edge 120 us after tx
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "sscc_consts.vh"
`default_nettype none
module sscc_synth_ctrl #(
  parameter ADDR_W = 8,
  parameter TX_WAKE_CYC = `SSCC_TX_WAKE_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire xtal_stable,
  input wire pll_lock_raw,
  output reg [23:0] synth_word,
  output reg pll_enable,
  output reg vco_cal_coarse,
  output reg vco_cal_fine,
  output reg path_enable,
  output reg tx_select,
  output reg data_bit_clock_start,
  output wire general_io_five,
  output reg lock_indicator,
  output wire irq
);
  // sequencer states, one-hot
  localparam [5:0] ST_OSC = 6'h01;
  localparam [5:0] ST_COARSE = 6'h02;
  localparam [5:0] ST_IDLE = 6'h04;
  localparam [5:0] ST_FINE = 6'h08;
  localparam [5:0] ST_LOCK = 6'h10;
  localparam [5:0] ST_RUN = 6'h20;

  reg [5:0] state_reg; // sequencer state
  reg [7:0] ctl_reg; // control bits
  reg [7:0] pinmap_reg; // pin_mapping_two
  reg [7:0] stage_msb_reg; // staged carrier high byte
  reg [7:0] stage_mid_reg; // staged carrier middle byte
  reg [7:0] stage_lsb_reg; // last written low byte
  reg [3:0] irq_stat_reg; // sticky event bits
  reg [3:0] irq_mask_reg; // interrupt enables
  reg osc_ok_reg; // crystal has been seen stable
  reg lock_q_reg; // previous lock, for edge events
  reg [ADDR_W-1:0] awaddr_reg; // held write address
  reg [31:0] wdata_reg; // held write data
  reg [3:0] wstrb_reg; // held strobes
  reg aw_full_reg; // write address held
  reg w_full_reg; // write data held
  reg [13:0] tx_cnt_reg; // transmit wake counter
  reg [3:0] ev_set; // events this cycle
  reg [31:0] rd_val; // read mux output
  reg rd_ok; // read address mapped
  wire wr_go; // both write halves present
  wire rd_go; // read taken
  wire [7:0] w_idx; // write register index
  wire [7:0] r_idx; // read register index
  wire cal_busy; // calibration timer running
  wire cal_done; // calibration timer expired
  reg cal_load; // start a calibration interval
  reg [11:0] cal_value; // length of calibration interval
  wire clk_en; // clock output allowed

  // register index from a byte address; used for both channels
  function [7:0] idx_of;
    input [ADDR_W-1:0] a;
    begin
      idx_of = a >> 2;
    end
  endfunction

  assign w_idx = idx_of(awaddr_reg);
  assign r_idx = idx_of(s_axi_araddr);
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read mux; upper bytes return staged values before commit
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (r_idx == `SSCC_IDX_CARRIER_MSB) begin
      rd_val[7:0] = stage_msb_reg;
    end else if (r_idx == `SSCC_IDX_CARRIER_MID) begin
      rd_val[7:0] = stage_mid_reg;
    end else if (r_idx == `SSCC_IDX_CARRIER_LSB) begin
      rd_val[7:0] = stage_lsb_reg;
    end else if (r_idx == `SSCC_IDX_CONTROL) begin
      rd_val[7:0] = ctl_reg;
    end else if (r_idx == `SSCC_IDX_STATUS) begin
      rd_val[11:0] = {osc_ok_reg, lock_indicator, path_enable, pll_enable,
                      2'b00, state_reg};
    end else if (r_idx == `SSCC_IDX_PIN_MAP_TWO) begin
      rd_val[7:0] = pinmap_reg;
    end else if (r_idx == `SSCC_IDX_IRQ_STATUS) begin
      rd_val[3:0] = irq_stat_reg;
    end else if (r_idx == `SSCC_IDX_IRQ_MASK) begin
      rd_val[3:0] = irq_mask_reg;
    end else if (r_idx == `SSCC_IDX_APPLIED) begin
      rd_val[23:0] = synth_word;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // event detection for sticky status bits
  always @* begin
    ev_set = 4'h0;
    ev_set[`SSCC_IRQ_OSC_READY] = xtal_stable && !osc_ok_reg;
    ev_set[`SSCC_IRQ_LOCK] = pll_lock_raw && !lock_q_reg;
    ev_set[`SSCC_IRQ_UNLOCK] = !pll_lock_raw && lock_q_reg;
    ev_set[`SSCC_IRQ_PATH_READY] = (state_reg == ST_LOCK) && pll_lock_raw;
  end

  // AXI write path, register writes and carrier staging
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= {ADDR_W{1'b0}};
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctl_reg <= `SSCC_CTL_RESET;
      pinmap_reg <= `SSCC_PINMAP2_RESET;
      stage_msb_reg <= 8'h00;
      stage_mid_reg <= 8'h00;
      stage_lsb_reg <= 8'h00;
      synth_word <= 24'h000000;
      irq_mask_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (!wstrb_reg[0]) begin
          // byte lane 0 not written: nothing stored
        end else if (w_idx == `SSCC_IDX_CARRIER_MSB) begin
          stage_msb_reg <= wdata_reg[7:0]; // held only
        end else if (w_idx == `SSCC_IDX_CARRIER_MID) begin
          stage_mid_reg <= wdata_reg[7:0]; // held only
        end else if (w_idx == `SSCC_IDX_CARRIER_LSB) begin
          stage_lsb_reg <= wdata_reg[7:0];
          // low byte commits the whole word
          synth_word <= {stage_msb_reg, stage_mid_reg, wdata_reg[7:0]};
        end else if (w_idx == `SSCC_IDX_CONTROL) begin
          ctl_reg <= wdata_reg[7:0];
        end else if (w_idx == `SSCC_IDX_PIN_MAP_TWO) begin
          pinmap_reg <= wdata_reg[7:0];
        end else if (w_idx == `SSCC_IDX_IRQ_MASK) begin
          irq_mask_reg <= wdata_reg[3:0];
        end else if (w_idx == `SSCC_IDX_IRQ_STATUS || w_idx == `SSCC_IDX_STATUS ||
                     w_idx == `SSCC_IDX_APPLIED) begin
          // read-only: write ignored with OKAY
        end else begin
          s_axi_bresp <= 2'b10; // unmapped: SLVERR
        end
      end
    end
  end

  // AXI read path; status read clears, new events win over the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      irq_stat_reg <= 4'h0;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
      if (rd_go && r_idx == `SSCC_IDX_IRQ_STATUS)
        irq_stat_reg <= ev_set;
      else
        irq_stat_reg <= irq_stat_reg | ev_set;
    end
  end

  // calibration interval timer
  sscc_timer #(
    .WIDTH(12)
  ) u_cal_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(cal_load),
    .value(cal_value),
    .busy(cal_busy),
    .done(cal_done)
  );

  // sequencer: osc settle, coarse cal, PLL start, fine cal, lock, path on
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_OSC;
      osc_ok_reg <= 1'b0;
      lock_q_reg <= 1'b0;
      lock_indicator <= 1'b0;
      pll_enable <= 1'b0;
      vco_cal_coarse <= 1'b0;
      vco_cal_fine <= 1'b0;
      path_enable <= 1'b0;
      tx_select <= 1'b0;
      cal_load <= 1'b0;
      cal_value <= 12'h000;
    end else begin
      cal_load <= 1'b0;
      lock_q_reg <= pll_lock_raw;
      lock_indicator <= pll_lock_raw && pll_enable;
      if (xtal_stable)
        osc_ok_reg <= 1'b1;
      case (state_reg)
        ST_OSC: begin
          if (xtal_stable) begin
            // no fixed wait: proceed as soon as the crystal is stable
            state_reg <= ST_COARSE;
            vco_cal_coarse <= 1'b1; // once after reset
            cal_load <= 1'b1;
            cal_value <= `SSCC_CAL_COARSE_CYC;
          end
        end
        ST_COARSE: begin
          if (cal_done) begin
            vco_cal_coarse <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          path_enable <= 1'b0;
          if (!ctl_reg[`SSCC_CTL_SLEEP] &&
              ((ctl_reg[`SSCC_CTL_SEQ_EN] &&
                (ctl_reg[`SSCC_CTL_TX_REQ] || ctl_reg[`SSCC_CTL_RX_REQ])) ||
               ctl_reg[`SSCC_CTL_SYNTH_REQ])) begin
            pll_enable <= 1'b1; // automatic PLL start
            vco_cal_fine <= 1'b1; // each PLL start
            cal_load <= 1'b1;
            cal_value <= `SSCC_CAL_FINE_CYC;
            state_reg <= ST_FINE;
          end
        end
        ST_FINE: begin
          if (cal_done) begin
            vco_cal_fine <= 1'b0;
            state_reg <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (ctl_reg[`SSCC_CTL_SLEEP] || !(ctl_reg[`SSCC_CTL_SYNTH_REQ] ||
              ctl_reg[`SSCC_CTL_TX_REQ] || ctl_reg[`SSCC_CTL_RX_REQ])) begin
            pll_enable <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (pll_lock_raw && ctl_reg[`SSCC_CTL_SEQ_EN] &&
                       (ctl_reg[`SSCC_CTL_TX_REQ] || ctl_reg[`SSCC_CTL_RX_REQ])) begin
            path_enable <= 1'b1; // start path on lock
            tx_select <= ctl_reg[`SSCC_CTL_TX_REQ];
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // a lock drop during wide FSK is not treated as failure here
          if (ctl_reg[`SSCC_CTL_SLEEP] ||
              !(ctl_reg[`SSCC_CTL_TX_REQ] || ctl_reg[`SSCC_CTL_RX_REQ])) begin
            path_enable <= 1'b0;
            pll_enable <= ctl_reg[`SSCC_CTL_SYNTH_REQ] && !ctl_reg[`SSCC_CTL_SLEEP];
            state_reg <= (ctl_reg[`SSCC_CTL_SYNTH_REQ] && !ctl_reg[`SSCC_CTL_SLEEP]) ?
                         ST_LOCK : ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_OSC;
        end
      endcase
    end
  end

  // transmit wake timing: first data clock edge after the wake interval
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_reg <= 14'h0000;
      data_bit_clock_start <= 1'b0;
    end else begin
      data_bit_clock_start <= 1'b0;
      if (!(path_enable && tx_select)) begin
        tx_cnt_reg <= 14'h0000;
      end else if (tx_cnt_reg != 14'h3FFF) begin
        tx_cnt_reg <= tx_cnt_reg + 14'h0001;
        if (tx_cnt_reg == TX_WAKE_CYC[13:0] - 14'h0001)
          data_bit_clock_start <= 1'b1;
      end
    end
  end

  // clock output: only after crystal stable, never in sleep
  assign clk_en = osc_ok_reg && !ctl_reg[`SSCC_CTL_SLEEP] &&
                  (pinmap_reg[2:0] != `SSCC_CLKSEL_OFF);

  sscc_clk_div #(
    .WIDTH(5)
  ) u_clk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(clk_en),
    .sel(pinmap_reg[2:0]),
    .clk_out(general_io_five)
  );

  // step size is implied downstream: synth_word times crystal over 2^19
endmodule // sscc_synth_ctrl
`default_nettype wire

// *** sscc_consts.vh ***
// Purpose: constants for the synthesizer start-up and clock-out block
// Assumes: 25 MHz aclk, AXI4-Lite register access, 32-bit words
// Notes: byte address of each register is four times its index
`ifndef SSCC_CONSTS_VH
`define SSCC_CONSTS_VH

// register indices (carrier bytes keep their printed offsets as indices)
`define SSCC_IDX_CARRIER_MSB 8'h07
`define SSCC_IDX_CARRIER_MID 8'h08
`define SSCC_IDX_CARRIER_LSB 8'h09
`define SSCC_IDX_CONTROL 8'h01
`define SSCC_IDX_STATUS 8'h02
`define SSCC_IDX_PIN_MAP_TWO 8'h26
`define SSCC_IDX_IRQ_STATUS 8'h03
`define SSCC_IDX_IRQ_MASK 8'h04
`define SSCC_IDX_APPLIED 8'h05

// control fields
`define SSCC_CTL_SEQ_EN 0
`define SSCC_CTL_SLEEP 1
`define SSCC_CTL_SYNTH_REQ 2
`define SSCC_CTL_TX_REQ 3
`define SSCC_CTL_RX_REQ 4
`define SSCC_CTL_RESET 8'h01

// clock output select encodings (3-bit field, low bits of pin_mapping_two)
`define SSCC_CLKSEL_DIV1 3'h0
`define SSCC_CLKSEL_DIV2 3'h1
`define SSCC_CLKSEL_DIV4 3'h2
`define SSCC_CLKSEL_DIV8 3'h3
`define SSCC_CLKSEL_DIV16 3'h4
`define SSCC_CLKSEL_DIV32 3'h5
`define SSCC_CLKSEL_RC 3'h6
`define SSCC_CLKSEL_OFF 3'h7
`define SSCC_PINMAP2_RESET 8'h00

// interrupt status bits
`define SSCC_IRQ_OSC_READY 0
`define SSCC_IRQ_LOCK 1
`define SSCC_IRQ_UNLOCK 2
`define SSCC_IRQ_PATH_READY 3

// synthesizer figures
`define SSCC_ACC_BITS 19
`define SSCC_CLK_MHZ 25
`define SSCC_TX_WAKE_US 120
`define SSCC_TX_WAKE_CYC (`SSCC_TX_WAKE_US * `SSCC_CLK_MHZ)
`define SSCC_CAL_COARSE_CYC 12'h040
`define SSCC_CAL_FINE_CYC 12'h010

`endif

// *** sscc_clk_div.v ***
// Purpose: reference clock output divider with gating
// Assumes: single clock domain, synchronous active-low reset
// Notes: output toggles from a flip-flop so it is glitch free
`include "sscc_consts.vh"
`default_nettype none
module sscc_clk_div #(
  parameter WIDTH = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire [2:0] sel,
  output reg clk_out
);
  reg [WIDTH-1:0] cnt_reg; // free running divider counter
  wire [WIDTH-1:0] low_mask; // counter bits that must be zero to toggle
  wire tap; // toggle this cycle

  // select k toggles every 2^k cycles; select 0 has an empty mask and toggles each cycle
  // selects beyond the counter width fall back to the slowest division
  assign low_mask = ~({WIDTH{1'b1}} << sel);
  assign tap = ((cnt_reg & low_mask) == {WIDTH{1'b0}});

  // counter and output toggle; gated low when disabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {WIDTH{1'b0}};
      clk_out <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= {WIDTH{1'b0}};
      clk_out <= 1'b0; // stopped: no transitions
    end else begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      if (tap)
        clk_out <= ~clk_out;
    end
  end
endmodule // sscc_clk_div
`default_nettype wire

// *** sscc_timer.v ***
// Purpose: load-and-count-down timer for calibration intervals
// Assumes: single clock, synchronous active-low reset
// Notes: done is a one-cycle pulse when the count reaches zero
`default_nettype none
module sscc_timer #(
  parameter WIDTH = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire load,
  input wire [WIDTH-1:0] value,
  output wire busy,
  output reg done
);
  reg [WIDTH-1:0] cnt_reg; // remaining cycles

  assign busy = (cnt_reg != {WIDTH{1'b0}});

  // load wins over counting so a restart is never lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= value;
      done <= 1'b0;
    end else begin
      done <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
      if (busy)
        cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // sscc_timer
`default_nettype wire

// *** sscc_synth_properties.sv ***
// Purpose: port-level checks for the synth start-up and clock-out block
// Assumes: one aclk domain, synchronous active-low aresetn
// Notes: bound to every sscc_synth_ctrl; wake count taken from the design
`default_nettype none
module sscc_synth_properties #(
  parameter int TX_WAKE_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic xtal_stable,
  input wire logic pll_lock_raw,
  input wire logic [23:0] synth_word,
  input wire logic pll_enable,
  input wire logic vco_cal_coarse,
  input wire logic vco_cal_fine,
  input wire logic path_enable,
  input wire logic tx_select,
  input wire logic data_bit_clock_start,
  input wire logic general_io_five,
  input wire logic lock_indicator
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] wake_cnt; // cycles since the tx path came up
  logic tx_on_q; // tx path state one cycle back
  // count from the first cycle the tx path is up; zero while it is down
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt <= 32'h0;
      tx_on_q <= 1'b0;
    end else begin
      tx_on_q <= path_enable && tx_select;
      if (!(path_enable && tx_select)) wake_cnt <= 32'h0;
      else if (!tx_on_q) wake_cnt <= 32'h1;
      else wake_cnt <= wake_cnt + 32'h1;
    end
  end
  chk_lock_follow: assert property (lock_indicator == ($past(pll_lock_raw) && $past(pll_enable)))
    else $error("lock indicator does not follow raw lock");
  chk_commit_edge: assert property (!$stable(synth_word) |-> $rose(s_axi_bvalid))
    else $error("carrier word changed outside a write response");
  chk_pll_xtal: assert property (pll_enable |-> xtal_stable)
    else $error("pll enabled without a stable crystal");
  chk_fine_cal: assert property ($rose(vco_cal_fine) |-> ##[0:20] pll_enable)
    else $error("fine calibration not tied to a pll start");
  chk_wake_time: assert property (data_bit_clock_start |-> wake_cnt == TX_WAKE_CYC)
    else $error("data clock start at wrong distance from tx start");
  chk_clk_silent: assert property (!xtal_stable && !$past(xtal_stable) |-> !general_io_five)
    else $error("clock output active before crystal stable");
  chk_path_pll: assert property ($rose(path_enable) |-> pll_enable)
    else $error("path started without pll");
  chk_coarse_before_pll: assert property (vco_cal_coarse |-> !pll_enable && !vco_cal_fine)
    else $error("coarse calibration overlaps a pll start");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property ($rose(lock_indicator));
  cover property ($rose(path_enable) && tx_select);
  cover property (data_bit_clock_start);
endmodule // sscc_synth_properties

bind sscc_synth_ctrl sscc_synth_properties #(.TX_WAKE_CYC(TX_WAKE_CYC)) sscc_synth_properties_inst (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready, .xtal_stable, .pll_lock_raw, .synth_word, .pll_enable,
  .vco_cal_coarse, .vco_cal_fine, .path_enable, .tx_select, .data_bit_clock_start,
  .general_io_five,
  .lock_indicator
);
`default_nettype wire

// *** sscc_analog_model.sv ***
// Purpose: crystal and pll model facing the synth control block
// Assumes: counts in aclk cycles, lock delay chosen by the bench
// Notes: lock can be knocked out to mimic wide-deviation fsk
`default_nettype none
module sscc_analog_model #(
  parameter int OSC_CYC = 60
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pll_enable,
  input wire logic drop_lock,
  input wire logic [7:0] lock_delay,
  output logic xtal_stable,
  output logic pll_lock_raw
);
  logic [7:0] osc_cnt; // settle counter from power-on
  logic [7:0] lock_cnt; // cycles since pll enable
  // crystal settles well inside the worst-case allowance
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= 8'h00;
      xtal_stable <= 1'b0;
    end else if (osc_cnt == 8'(OSC_CYC)) xtal_stable <= 1'b1;
    else osc_cnt <= osc_cnt + 8'h01;
  end
  // lock after a prompt or slow delay; drop_lock forces an unlock
  always @(posedge aclk) begin
    if (!aresetn || !pll_enable) begin
      lock_cnt <= 8'h00;
      pll_lock_raw <= 1'b0;
    end else begin
      if (lock_cnt != lock_delay) lock_cnt <= lock_cnt + 8'h01;
      pll_lock_raw <= (lock_cnt == lock_delay) && !drop_lock;
    end
  end
endmodule // sscc_analog_model
`default_nettype wire

// *** tb_sscc_synth_ctrl.sv ***
// Purpose: self-checking bench for the synth start-up and clock-out block
// Assumes: 25 MHz aclk, reset held 20 cycles, tx wake shortened to 20
// Notes: bus answers are sampled at the falling edge before their edge
`include "sscc_consts.vh"
`default_nettype none
module tb_sscc_synth_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE = 20;
  localparam logic [7:0] MSB = `SSCC_IDX_CARRIER_MSB;
  localparam logic [7:0] MID = `SSCC_IDX_CARRIER_MID;
  localparam logic [7:0] LSB = `SSCC_IDX_CARRIER_LSB;
  localparam logic [7:0] CTL = `SSCC_IDX_CONTROL;
  localparam logic [7:0] PIN = `SSCC_IDX_PIN_MAP_TWO;
  localparam logic [7:0] IST = `SSCC_IDX_IRQ_STATUS;
  localparam logic [7:0] MSK = `SSCC_IDX_IRQ_MASK;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, lock_delay = 8'h0A;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, drop_lock = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, d;
  logic [3:0] s_axi_wstrb = 4'hF; // full words only
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] synth_word;
  wire xtal_stable, pll_lock_raw, pll_enable, path_enable, tx_select, irq;
  wire data_bit_clock_start, general_io_five, lock_indicator;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;
  sscc_synth_ctrl #(.ADDR_W(8), .TX_WAKE_CYC(WAKE)) sscc_synth_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xtal_stable, .pll_lock_raw,
    .synth_word, .pll_enable, .vco_cal_coarse(), .vco_cal_fine(), .path_enable,
    .tx_select, .data_bit_clock_start, .general_io_five, .lock_indicator, .irq);
  sscc_analog_model sscc_analog_model_inst (
    .aclk, .aresetn, .pll_enable, .drop_lock, .lock_delay, .xtal_stable, .pll_lock_raw);
  // 40 ns clock
  always #20 aclk = ~aclk;
  // hang guard, well above the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wchk(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
  endtask
  task automatic rd(input logic [7:0] idx);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tb);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    rd(idx);
    chk(nm, e, d);
  endtask
  // half period of the clock output, skipping the partial first one
  task automatic half;
    logic g;
    @(negedge aclk);
    repeat (2) begin
      g = general_io_five;
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (general_io_five === g);
    end
  endtask
  // count cycles with the clock output not low; gating acts before the write returns
  task automatic still;
    n = 0;
    repeat (42) begin
      @(negedge aclk);
      if (general_io_five !== 1'b0) n++;
    end
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("clock out at start", 0, general_io_five);
    rchk(MSB, 0, "carrier msb");
    rchk(PIN, `SSCC_PINMAP2_RESET, "pin map two");
    rchk(CTL, 1, "control");
    rchk(MSK, 0, "irq mask");
    while (general_io_five !== 1'b1) @(negedge aclk);
    half;
    chk("clock half period", 1, n);
    rd(IST);
    chk("osc ready event", 1, d & 1);
    chk("irq masked", 0, irq);
    $display("test reset finished");
    wchk(MSB, 32'hAB, 0);
    wchk(MID, 32'hCD, 0);
    chk("word held", 0, synth_word);
    rchk(MSB, 32'hAB, "msb staged");
    rchk(MID, 32'hCD, "mid staged");
    wchk(LSB, 32'hEF, 0);
    chk("word", 32'hABCDEF, synth_word);
    rchk(`SSCC_IDX_APPLIED, 32'hABCDEF, "applied");
    wchk(MSB, 32'h12, 0);
    chk("word kept", 32'hABCDEF, synth_word);
    wchk(LSB, 32'h34, 0);
    chk("word", 32'h12CD34, synth_word);
    wchk(8'h30, 32'h5, 2);
    rchk(8'h30, 0, "unmapped data");
    chk("unmapped resp", 2, r);
    wchk(`SSCC_IDX_STATUS, 32'hFFF, 0);
    $display("test carrier finished");
    for (int s = 0; s < 6; s++) begin
      wchk(PIN, s, 0);
      half;
      chk("clock half period", 1 << s, n);
    end
    wchk(PIN, `SSCC_CLKSEL_OFF, 0);
    still;
    chk("clock off", 0, n);
    wchk(PIN, `SSCC_CLKSEL_DIV1, 0);
    wchk(CTL, 32'h3, 0);
    still;
    chk("clock in sleep", 0, n);
    wchk(CTL, 32'h1, 0);
    half;
    chk("clock after sleep", 1, n);
    $display("test clock out finished");
    wchk(MSK, 32'h2, 0);
    rd(IST);
    wchk(CTL, 32'h9, 0);
    @(negedge aclk);
    while (path_enable !== 1'b1) @(negedge aclk);
    n = 0;
    while (data_bit_clock_start !== 1'b1) begin
      @(negedge aclk);
      n++;
    end
    chk("tx wake", WAKE, n);
    chk("tx select", 1, tx_select);
    chk("lock ind", 1, lock_indicator);
    chk("irq lock", 1, irq);
    rd(IST);
    chk("lock event", 1, d[1]);
    @(negedge aclk);
    chk("irq cleared", 0, irq);
    wchk(MSK, 32'h4, 0);
    drop_lock <= 1'b1;
    repeat (4) @(negedge aclk);
    chk("lock dropped", 0, lock_indicator);
    chk("irq unlock", 1, irq);
    @(posedge aclk);
    drop_lock <= 1'b0;
    rd(IST);
    chk("unlock event", 1, d[2]);
    $display("test sequencer finished");
    wchk(CTL, 32'h0, 0);
    lock_delay <= 8'h01;
    wchk(CTL, 32'h4, 0);
    @(negedge aclk);
    while (lock_indicator !== 1'b1) @(negedge aclk);
    repeat (30) @(negedge aclk);
    chk("manual path", 0, path_enable);
    $display("test manual finished");
    conclude;
  end
endmodule // tb_sscc_synth_ctrl
`default_nettype wire
